// ---- logic/ocg_consts.svh ----
// constants for the overcurrent and thermal fault guard
// assumes a 125 MHz system clock
`ifndef OCG_CONSTS_SVH
`define OCG_CONSTS_SVH
`define OCG_CLK_MHZ         125
`define OCG_SLOT_NS         10000
`define OCG_SLOT_CYC        (`OCG_SLOT_NS * `OCG_CLK_MHZ / 1000)
`define OCG_WINDOW_SLOTS    5000
`define OCG_TRIP_LIMIT      7
`define OCG_LONG_MS         1300
`define OCG_SHORT_MS        150
`define OCG_LONG_SLOTS      (`OCG_LONG_MS * 100)
`define OCG_SHORT_SLOTS     (`OCG_SHORT_MS * 100)
`define OCG_THERM_US        100
`define OCG_THERM_SLOTS     (`OCG_THERM_US / 10)
`define OCG_SEL_LONG_BIT    11
`define OCG_OC_DIS_BIT      1
`endif

// ---- logic/ocg_guard.sv ----
// overcurrent and thermal fault guard top
// assumes comparator inputs synchronous to sys_clk_in, control bits static
`include "ocg_consts.svh"
// Functional notes
// (RULE_01) Either adapter or battery discharge comparator counts as a trip.
// (RULE_02) The trip counter rises at most once per 10 us slot.
// (RULE_03) Seven trips within one 50 ms window declare a fault.
// (RULE_04) A fault drops the gate, adapter present and switching at once.
// (RULE_05) After a fault wait 1.3 s or 150 ms by bit 11, then restart.
// (RULE_06) Disable bit 1 ignores trips and blocks any fault.
// (RULE_07) Over-temperature stops switching.
// (RULE_08) Switching resumes 100 us after temperature falls below low point.
// (RULE_09) The counter clears at window end and when a fault is declared.
module ocg_guard (
    // clock and reset
    input  wire logic        sys_clk_in,
    input  wire logic        reset_in,
    // comparators
    input  wire logic        adapter_overcurrent_in,
    input  wire logic        battery_overcurrent_in,
    input  wire logic        over_temp_in,
    input  wire logic        under_low_temp_in,
    // second control register bits
    input  wire logic [15:0] second_control_reg_in,
    // power stage control
    output logic             adapter_isolation_gate_out,
    output logic             adapter_present_out,
    output logic             switching_enable_out,
    output ocg_pkg::ocg_status_s status_out
);
    localparam logic [12:0] WIN_LAST = 13'(`OCG_WINDOW_SLOTS - 1);
    localparam logic [2:0] TRIP_LIM = 3'(`OCG_TRIP_LIMIT);
    // waits run one tick past the slot count: a partial first slot
    // never shortens the debounce or the cooling delay
    localparam logic [17:0] LONG_W = 18'(`OCG_LONG_SLOTS);
    localparam logic [17:0] SHORT_W = 18'(`OCG_SHORT_SLOTS);
    localparam logic [3:0] THERM_W = 4'(`OCG_THERM_SLOTS);

    // ==========================================================
    // slot time base
    logic slot_tick;
    ocg_slot_timer u_slot (
        .sys_clk_in    (sys_clk_in),
        .reset_in      (reset_in),
        .slot_tick_out (slot_tick)
    );

    // ==========================================================
    // trip counting
    logic               trip;
    logic               oc_dis;
    logic [12:0]        win_q;
    logic [2:0]         trips_q;
    logic               slot_hit_q;
    logic               slot_seen;
    logic               win_end;
    logic               fault_now;
    ocg_pkg::ocg_state_e state_q;
    assign oc_dis = second_control_reg_in[`OCG_OC_DIS_BIT];
    assign trip = (adapter_overcurrent_in | battery_overcurrent_in)
                  & ~oc_dis; // see RULE_01 see RULE_06
    // the tick cycle already opens the next slot
    assign slot_seen = slot_hit_q & ~slot_tick;
    // last slot of the fixed window hands over on this tick
    assign win_end = slot_tick & (win_q == WIN_LAST);
    // no fault from trips that straddle a window boundary
    assign fault_now = (state_q == ocg_pkg::OCG_RUN) & trip & ~slot_seen
                       & ~win_end
                       & (trips_q == TRIP_LIM - 3'h1); // see RULE_03

    always_ff @(posedge sys_clk_in or posedge reset_in)
        if (reset_in)
            win_q <= 13'h0000;
        else if (slot_tick)
            win_q <= (win_q == WIN_LAST) ? 13'h0000 : win_q + 13'h0001;

    always_ff @(posedge sys_clk_in or posedge reset_in)
        if (reset_in)
            slot_hit_q <= 1'b0;
        else if (trip)
            slot_hit_q <= 1'b1; // see RULE_02
        else if (slot_tick)
            slot_hit_q <= 1'b0;

    always_ff @(posedge sys_clk_in or posedge reset_in)
        if (reset_in)
            trips_q <= 3'h0;
        else if (fault_now || state_q != ocg_pkg::OCG_RUN || oc_dis)
            trips_q <= 3'h0; // see RULE_09
        else if (win_end)
            trips_q <= {2'h0, trip & ~slot_seen}; // see RULE_09
        else if (trip && !slot_seen)
            trips_q <= trips_q + 3'h1; // see RULE_02

    // ==========================================================
    // fault and retry
    logic [17:0] deb_q;
    always_ff @(posedge sys_clk_in or posedge reset_in)
        if (reset_in)
        begin
            state_q <= ocg_pkg::OCG_RUN;
            deb_q <= 18'h00000;
        end
        else
        begin
            case (state_q)
                ocg_pkg::OCG_RUN:
                    if (fault_now)
                    begin
                        state_q <= ocg_pkg::OCG_FAULT; // see RULE_04
                        deb_q <= 18'h00000;
                    end
                ocg_pkg::OCG_FAULT:
                    if (slot_tick)
                    begin
                        if (deb_q == (second_control_reg_in[`OCG_SEL_LONG_BIT]
                                      ? LONG_W : SHORT_W))
                            state_q <= ocg_pkg::OCG_RETRY; // see RULE_05
                        else
                            deb_q <= deb_q + 18'h00001;
                    end
                ocg_pkg::OCG_RETRY:
                    state_q <= ocg_pkg::OCG_RUN;
                default:
                    state_q <= ocg_pkg::OCG_RUN;
            endcase
        end

    // ==========================================================
    // thermal
    logic       hot_q;
    logic [3:0] cool_q;
    always_ff @(posedge sys_clk_in or posedge reset_in)
        if (reset_in)
        begin
            hot_q <= 1'b0;
            cool_q <= 4'h0;
        end
        else if (over_temp_in)
        begin
            hot_q <= 1'b1; // see RULE_07
            cool_q <= 4'h0;
        end
        else if (hot_q && !under_low_temp_in)
            cool_q <= 4'h0;
        else if (hot_q && slot_tick)
        begin
            if (cool_q == THERM_W)
                hot_q <= 1'b0; // see RULE_08
            else
                cool_q <= cool_q + 4'h1;
        end

    // ==========================================================
    // outputs
    logic run_ok;
    assign run_ok = (state_q == ocg_pkg::OCG_RUN) & ~fault_now;
    always_ff @(posedge sys_clk_in or posedge reset_in)
        if (reset_in)
        begin
            adapter_isolation_gate_out <= 1'b0;
            adapter_present_out <= 1'b0;
            switching_enable_out <= 1'b0;
            status_out <= '0;
        end
        else
        begin
            adapter_isolation_gate_out <= run_ok; // see RULE_04
            adapter_present_out <= run_ok;
            switching_enable_out <= run_ok & ~over_temp_in & ~hot_q;
            status_out.adapter_gate_on <= run_ok;
            status_out.adapter_present <= run_ok;
            status_out.switching_enable <= run_ok & ~over_temp_in & ~hot_q;
            status_out.oc_fault <= ~run_ok;
            status_out.thermal_stop <= over_temp_in | hot_q;
        end

    // ==========================================================
    // checks
    one_count_slot_a: assert property (@(posedge sys_clk_in) // see RULE_02
        disable iff (reset_in) slot_hit_q && !slot_tick
        |=> trips_q == $past(trips_q) || trips_q == 3'h0)
        else $error("trip counted twice in slot");
    fault_drops_gate_a: assert property (@(posedge sys_clk_in) // see RULE_04
        disable iff (reset_in) fault_now
        |=> !adapter_isolation_gate_out && !adapter_present_out
            && !switching_enable_out)
        else $error("fault did not drop outputs");
    disable_no_fault_a: assert property (@(posedge sys_clk_in) // see RULE_06
        disable iff (reset_in) oc_dis |-> !fault_now)
        else $error("fault while disabled");
    hot_stops_sw_a: assert property (@(posedge sys_clk_in) // see RULE_07
        disable iff (reset_in) over_temp_in |=> !switching_enable_out)
        else $error("switching while hot");
    cool_delay_a: assert property (@(posedge sys_clk_in) // see RULE_08
        disable iff (reset_in) $fell(hot_q) |-> cool_q == THERM_W)
        else $error("thermal resume early");
    fault_clears_a: assert property (@(posedge sys_clk_in) // see RULE_09
        disable iff (reset_in) fault_now |=> trips_q == 3'h0)
        else $error("counter not cleared on fault");
    window_clear_a: assert property (@(posedge sys_clk_in) // see RULE_09
        disable iff (reset_in) win_end && !trip |=> trips_q == 3'h0)
        else $error("counter not cleared at window end");
    fault_at_seven_a: assert property (@(posedge sys_clk_in) // see RULE_03
        disable iff (reset_in) $rose(state_q == ocg_pkg::OCG_FAULT)
        |-> $past(trips_q) == 3'h6)
        else $error("fault not at seventh trip");
    retry_wait_a: assert property (@(posedge sys_clk_in) // see RULE_05
        disable iff (reset_in) state_q == ocg_pkg::OCG_RETRY
        |-> deb_q == SHORT_W || deb_q == LONG_W)
        else $error("retry before debounce");
    retry_restores_a: assert property (@(posedge sys_clk_in) // see RULE_05
        disable iff (reset_in) state_q == ocg_pkg::OCG_RETRY
        |-> ##2 adapter_isolation_gate_out && adapter_present_out)
        else $error("retry did not restore outputs");
    fault_seen_c: cover property (@(posedge sys_clk_in) fault_now);
    retry_seen_c: cover property (@(posedge sys_clk_in)
        state_q == ocg_pkg::OCG_RETRY);
    thermal_seen_c: cover property (@(posedge sys_clk_in) $fell(hot_q));
    window_end_c: cover property (@(posedge sys_clk_in)
        win_end && trips_q != 3'h0);
    masked_trip_c: cover property (@(posedge sys_clk_in)
        oc_dis && (adapter_overcurrent_in || battery_overcurrent_in));
endmodule // ocg_guard

// ---- logic/ocg_pkg.sv ----
// types for the overcurrent and thermal fault guard
// assumes ocg_consts.svh beside it
package ocg_pkg;
    typedef enum logic [1:0] {OCG_RUN, OCG_FAULT, OCG_RETRY} ocg_state_e;
    typedef struct packed {
        logic adapter_gate_on;
        logic adapter_present;
        logic switching_enable;
        logic oc_fault;
        logic thermal_stop;
    } ocg_status_s;
endpackage

// ---- logic/ocg_slot_timer.sv ----
// slot divider: one-cycle pulse every 10 us
// assumes a 125 MHz clock
`include "ocg_consts.svh"
module ocg_slot_timer (
    // clock and reset
    input  wire logic sys_clk_in,
    input  wire logic reset_in,
    // slot pulse
    output logic      slot_tick_out
);
    localparam logic [10:0] SLOT_LAST = 11'(`OCG_SLOT_CYC - 1);
    logic [10:0] div_q;
    always_ff @(posedge sys_clk_in or posedge reset_in)
        if (reset_in)
        begin
            div_q <= 11'h000;
            slot_tick_out <= 1'b0;
        end
        else
        begin
            slot_tick_out <= (div_q == SLOT_LAST);
            div_q <= (div_q == SLOT_LAST) ? 11'h000 : div_q + 11'h001;
        end
endmodule // ocg_slot_timer

// ---- sim/ocg_guard_bench.sv ----
// self-checking bench for the fault guard
// assumes the comparator model; retry waits of 150 ms are not run
module ocg_guard_bench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SLOT = 1250;
    logic                sys_clk_in  = 1'b0;
    logic                reset_in    = 1'b1;
    logic                trip_q      = 1'b0;
    logic                hot_q       = 1'b0;
    logic                chk_q       = 1'b0;
    logic [1:0]          mix_q       = 2'h0;
    logic [15:0]         ctrl_q      = 16'h0000;
    logic                adp_oc;
    logic                bat_oc;
    logic                over_t;
    logic                low_t;
    logic                gate;
    logic                present;
    logic                sw;
    ocg_pkg::ocg_status_s st;
    integer              seed        = 32'hE656;
    int                  failures    = 0;
    int                  checks_done = 0;
    logic [7:0]          exp_q[$];

    always #4 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) mix_q <= 2'($random(seed));

    ocg_power_stage stage_u (
        .sys_clk_in     (sys_clk_in),
        .trip_in        (trip_q),
        .mix_in         (mix_q),
        .hot_in         (hot_q),
        .adapter_oc_out (adp_oc),
        .battery_oc_out (bat_oc),
        .over_temp_out  (over_t),
        .low_temp_out   (low_t)
    );
    ocg_guard dut_u (
        .sys_clk_in                 (sys_clk_in),
        .reset_in                   (reset_in),
        .adapter_overcurrent_in     (adp_oc),
        .battery_overcurrent_in     (bat_oc),
        .over_temp_in               (over_t),
        .under_low_temp_in          (low_t),
        .second_control_reg_in      (ctrl_q),
        .adapter_isolation_gate_out (gate),
        .adapter_present_out        (present),
        .switching_enable_out       (sw),
        .status_out                 (st)
    );

    // ==========================================================
    // checking
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask
    // v: gate, present, switching, fault, thermal stop
    task automatic expect_st(input logic [4:0] v);
        exp_q.push_back({v[4:2], v});
        chk_q <= 1'b1;
        @(posedge sys_clk_in);
        chk_q <= 1'b0;
    endtask
    task automatic compare_st(input string nm, input logic [7:0] e,
                              input logic [7:0] g);
        checks_done++;
        if (g !== e)
        begin
            failures++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    always @(negedge sys_clk_in)
    begin
        if (chk_q === 1'b1)
            compare_st("outputs", exp_q.pop_front(), {gate, present, sw, st});
    end
    task automatic end_of_test;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // ==========================================================
    // stimulus
    initial
    begin
        wait_cyc(16);
        reset_in <= 1'b0;
        wait_cyc(3);
        expect_st(5'b11100);
        hot_q <= 1'b1;
        wait_cyc(2);
        expect_st(5'b11001);
        hot_q <= 1'b0;
        wait_cyc(200 + 8 * SLOT);
        expect_st(5'b11001);
        wait_cyc(3 * SLOT + 4);
        expect_st(5'b11100);
        // guard disabled, retry select short, other bits random
        ctrl_q <= (16'($random(seed)) & 16'hF7FF) | 16'h0002;
        trip_q <= 1'b1;
        wait_cyc(9 * SLOT);
        expect_st(5'b11100);
        trip_q <= 1'b0;
        ctrl_q <= ctrl_q & 16'hFFFD;
        wait_cyc(2);
        trip_q <= 1'b1;
        wait_cyc(5 * SLOT);
        expect_st(5'b11100);
        wait_cyc(2 * SLOT + 4);
        expect_st(5'b00010);
        trip_q <= 1'b0;
        wait_cyc(10 * SLOT);
        expect_st(5'b00010);
        end_of_test();
    end
    initial
    begin
        #(60000 * 8);
        failures++;
        end_of_test();
    end
endmodule // ocg_guard_bench

// ---- sim/ocg_power_stage.sv ----
// comparator model of the power stage beside the fault guard
// assumes commands from the bench at the rising clock edge
module ocg_power_stage (
    // clock
    input  wire logic       sys_clk_in,
    // commands
    input  wire logic       trip_in,
    input  wire logic [1:0] mix_in,
    input  wire logic       hot_in,
    // comparator outputs
    output logic            adapter_oc_out,
    output logic            battery_oc_out,
    output logic            over_temp_out,
    output logic            low_temp_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] band_q = 8'h00;
    // one or both comparators high while tripping
    assign adapter_oc_out = trip_in & mix_in[0];
    assign battery_oc_out = trip_in & (mix_in[1] | ~mix_in[0]);
    assign over_temp_out  = hot_in;
    // cooling passes the band between both thresholds
    always @(posedge sys_clk_in)
    begin
        if (hot_in)
            band_q <= 8'hC8;
        else if (band_q != 8'h00)
            band_q <= band_q - 8'h01;
    end
    assign low_temp_out = ~hot_in & (band_q == 8'h00);
endmodule // ocg_power_stage
